// File: bench/spm_checker.sv
// Checker: timing relations at the sleep and power manager ports.
// Assumes binding to spm_sleep_power_manager; one clock domain.
`timescale 1ns/1ps
module spm_checker
	import spm_pkg::*;
(
	// Clock, reset and bus
	input wire logic        sys_clk, reset, psel, penable, pwrite, pready,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// Core handshake and configuration
	input wire logic        sleepExec, coreHold, resumeAfterSleep, watchdogOn, compUsesRef,
	// Clock and analog controls
	input wire logic        coreClkEn, progClkEn, ioClkEn, convClkEn, oscEn, monitorFuseOn,
	input wire logic        compDisable, refKeep, monitorOn, watchdogRun, inBufEn,
	input wire logic [3:0]  periphClkEn
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// =====
	// Sequences
	sequence s_setup; psel && !penable; endsequence
	sequence s_deep; !ioClkEn && !convClkEn; endsequence
	sequence s_gate_wr; psel && penable && pready && pwrite && paddr == GATE_OFS; endsequence

	// =====
	// Properties
	property p_answer; s_setup |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");
	property p_entry; $rose(coreHold) |-> $past(sleepExec); endproperty
	a_entry: assert property (p_entry) else $error("hold without sleep");
	property p_resume; resumeAfterSleep |=> !resumeAfterSleep && !coreHold; endproperty
	a_resume: assert property (p_resume) else $error("resume not clean");
	property p_io; !ioClkEn |-> !coreClkEn && !progClkEn; endproperty
	a_io: assert property (p_io) else $error("io stopped, core running");
	property p_osc; !oscEn |-> !coreClkEn && !ioClkEn && !convClkEn; endproperty
	a_osc: assert property (p_osc) else $error("clock without oscillator");
	property p_mon; monitorFuseOn && !monitorOn |-> coreHold && !ioClkEn; endproperty
	a_mon: assert property (p_mon) else $error("monitor off while awake");
	property p_gate; s_gate_wr |-> ##2 (periphClkEn ^ $past(pwdata[3:0], 2)) == 4'hF; endproperty
	a_gate: assert property (p_gate) else $error("gate write not applied");
	property p_comp; s_deep |-> compDisable && (refKeep || !compUsesRef); endproperty
	a_comp: assert property (p_comp) else $error("comparator in deep sleep");
	property p_inbuf; s_deep |-> !inBufEn; endproperty
	a_inbuf: assert property (p_inbuf) else $error("input buffers on");
	property p_wdog; watchdogOn [*2] |-> watchdogRun; endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog stopped");
endmodule : spm_checker

bind spm_sleep_power_manager spm_checker u_chk (.sys_clk, .reset, .psel, .penable, .pwrite,
	.pready, .paddr, .pwdata, .sleepExec, .coreHold, .resumeAfterSleep, .watchdogOn,
	.compUsesRef, .coreClkEn, .progClkEn, .ioClkEn, .convClkEn, .oscEn, .monitorFuseOn,
	.compDisable, .refKeep, .monitorOn, .watchdogRun, .inBufEn, .periphClkEn);

// File: bench/spm_core_model.sv
// Core model: issues the sleep instruction and stalls while held.
// Assumes the manager answers through coreHold.
`timescale 1ns/1ps
module spm_core_model (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Bench request and manager answer
	input  wire logic go,
	input  wire logic coreHold,
	output logic      sleepExec
);
	// =====
	// One-cycle sleep instruction, never issued while stalled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sleepExec <= 1'b0;
		end else begin
			sleepExec <= go && !coreHold && !sleepExec;
		end
	end
endmodule : spm_core_model

// File: bench/tb_spm_sleep_power_manager.sv
// Bench: registers, gating, all four sleep kinds, wake timing, monitor off.
// Assumes the manager, the core model and the bound checker.
`timescale 1ns/1ps
module tb_spm_sleep_power_manager
	import spm_pkg::*;
;
	localparam int SU = 5;
	localparam int MW = 20;
	logic        sys_clk, reset, psel, penable, pwrite, go, crystalSelected, convEnabled;
	logic        compUsesRef, monitorFuseOn, watchdogOn, pready, pslverr, sleepExec;
	logic        coreHold, resumeAfterSleep, convStart, coreClkEn, progClkEn, ioClkEn;
	logic        convClkEn, oscEn, compDisable, refKeep, monitorOn, watchdogRun, inBufEn;
	logic        sawStart, lastErr, convExtended;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  periphClkEn;
	logic [5:0]  irqs;
	int          num_errors, num_checks, k, n;
	// Per kind: {hold,core,io,conv,osc,inbuf,compoff}, refused and waking sources
	logic [6:0]  clkExp [4] = '{7'h5E, 7'h4E, 7'h41, 7'h45};
	logic [5:0]  badIrq [4] = '{6'h00, 6'h20, 6'h18, 6'h30};
	logic [5:0]  goodIrq [4] = '{6'h20, 6'h10, 6'h04, 6'h02};
	int          wakeExp [4] = '{SU + IRQ_EXTRA, SU + IRQ_EXTRA, SU + IRQ_EXTRA, STANDBY_WAKE};

	spm_sleep_power_manager #(.START_UP_CYC(SU), .MON_WAKE(MW)) dut (
		.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sleepExec, .coreHold, .resumeAfterSleep, .anyIrq(irqs[5]),
		.convDoneIrq(irqs[4]), .storeReadyIrq(irqs[3]), .lineZeroLevelIrq(irqs[2]),
		.pinChangeIrq(irqs[1]), .watchdogIrq(irqs[0]), .anyReset(1'b0), .crystalSelected,
		.convEnabled, .compUsesRef, .monitorFuseOn, .watchdogOn, .coreClkEn, .progClkEn,
		.ioClkEn, .convClkEn, .oscEn, .periphClkEn, .convStart, .convExtended,
		.compDisable, .refKeep, .monitorOn, .watchdogRun, .inBufEn, .wakePinBufEn());
	spm_core_model core (.sys_clk, .reset, .go, .coreHold, .sleepExec);

	// =====
	// Clock and conversion-start watch
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (convStart === 1'b1) sawStart <= 1'b1;

	// =====
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	// APB transfer held until pready; bounded wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		r = prdata;
		lastErr = pslverr;
		{psel, penable} <= 2'b00;
		#1;
		if (pready !== 1'b1 && i >= 20) begin
			num_errors++;
			give_verdict();
		end
	endtask : apb

	task automatic sleep_now();
		@(posedge sys_clk) go <= 1'b1;
		@(posedge sys_clk) go <= 1'b0;
	endtask : sleep_now

	// Counts edges from a wake event to the resume pulse
	task automatic wait_resume(input int exp);
		for (n = 1; n < 900; n++) begin
			@(posedge sys_clk);
			#1;
			if (resumeAfterSleep === 1'b1) break;
		end
		check(n, exp);
		if (n >= 900) give_verdict();
		@(posedge sys_clk) irqs <= 6'h00;
	endtask : wait_resume

	// =====
	// Main sequence
	initial begin
		{psel, penable, pwrite, go, crystalSelected, monitorFuseOn} = 6'b000011;
		{convEnabled, compUsesRef, watchdogOn, sawStart} = 4'h0;
		{paddr, pwdata, irqs} = '0;
		num_errors = 0;
		num_checks = 0;
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		apb(1'b0, CORE_CTRL_OFS, 32'h0);
		check(r, 32'h0);
		check(monitorOn, 1'b1);
		apb(1'b0, GATE_OFS, 32'h0);
		check(r, 32'h0);
		apb(1'b1, GATE_OFS, 32'hFF);
		@(posedge sys_clk);
		#1;
		check(periphClkEn, 4'h0);
		apb(1'b0, GATE_OFS, 32'h0);
		check(r, 32'h0F);
		apb(1'b1, GATE_OFS, 32'h05);
		@(posedge sys_clk);
		#1;
		check(periphClkEn, 4'hA);
		apb(1'b0, 8'h0C, 32'h0);
		check(lastErr, 1'b1);
		$display("registers done");
		// Sleep without the arm bit must not stall the core
		apb(1'b1, CORE_CTRL_OFS, 32'h10);
		sleep_now();
		repeat (4) @(posedge sys_clk);
		check(coreHold, 1'b0);
		for (k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			{convEnabled, watchdogOn, compUsesRef} <= {k != 3, k[0], k[0]};
			apb(1'b1, CORE_CTRL_OFS, 32'(32'h20 | (k << 3)));
			sawStart = 1'b0;
			sleep_now();
			repeat (3) @(posedge sys_clk);
			#1;
			check({coreHold, coreClkEn, ioClkEn, convClkEn, oscEn, inBufEn, compDisable},
				clkExp[k]);
			check(sawStart, k < 2);
			check(convExtended, 1'b0);
			@(posedge sys_clk) irqs <= badIrq[k];
			repeat (8) @(posedge sys_clk);
			check(coreHold, 1'b1);
			irqs <= goodIrq[k];
			wait_resume(wakeExp[k] + 1);
			$display("sleep kind %0d done", k);
		end
		convEnabled <= 1'b1;
		apb(1'b1, CORE_CTRL_OFS, 32'hB4);
		apb(1'b1, CORE_CTRL_OFS, 32'hB0);
		// Off bit turns active three edges after the write; sleep must see it
		@(posedge sys_clk);
		sleep_now();
		repeat (3) @(posedge sys_clk);
		check(monitorOn, 1'b0);
		@(posedge sys_clk) irqs <= 6'h02;
		wait_resume(MW + 1);
		check(monitorOn, 1'b1);
		check(convExtended, 1'b1);
		$display("monitor off done");
		give_verdict();
	end
endmodule : tb_spm_sleep_power_manager

// File: design/spm_pkg.sv
// Constants for the sleep and power manager: register map, fields, timing.
// Assumes a 10 MHz system clock and APB with 32-bit data.
package spm_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CORE_CTRL_OFS  = 8'h00; // core_control_reg
	localparam logic [7:0] GATE_OFS       = 8'h04; // peripheral_clock_gate_reg
	localparam logic [7:0] STATUS_OFS     = 8'h08; // sleep status

	// ==========================================================
	// Core control fields
	localparam int MON_OFF_BIT   = 7;
	localparam int ARM_BIT       = 5;
	localparam int KIND_HI_BIT   = 4;
	localparam int KIND_LO_BIT   = 3;
	localparam int UNLOCK_BIT    = 2;
	localparam logic [7:0] CORE_CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL_RW_MASK  = 8'h38;

	// Gate fields
	localparam int GATE_T1_BIT   = 3;
	localparam int GATE_T0_BIT   = 2;
	localparam int GATE_SER_BIT  = 1;
	localparam int GATE_CONV_BIT = 0;
	localparam logic [3:0] GATE_RST = 4'h0;

	// ==========================================================
	// Sleep kinds and sequencer states
	typedef enum logic [1:0] {
		SPM_IDLE    = 2'b00,
		SPM_NOISE   = 2'b01,
		SPM_PWRDOWN = 2'b10,
		SPM_STANDBY = 2'b11
	} spm_kind_t;

	typedef enum logic [1:0] {
		SPM_RUN   = 2'b00,
		SPM_SLEEP = 2'b01,
		SPM_WAKE  = 2'b10
	} spm_state_t;

	// ==========================================================
	// Timing
	localparam int CLK_HZ          = 10_000_000;
	localparam int UNLOCK_WINDOW   = 4;
	localparam int MON_OFF_DELAY   = 3;
	localparam int MON_OFF_HOLD    = 3;
	localparam int IRQ_EXTRA       = 4;
	localparam int STANDBY_WAKE    = 6;
	localparam int MON_WAKE_NS     = 60_000;
	localparam int MON_WAKE_CYC    = (MON_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : spm_pkg

// File: design/spm_sleep_power_manager.sv
// Sleep and power manager: sleep entry, clock-domain gating, wake, monitor off.
// Assumes the core pulses sleepExec for the sleep instruction and waits on coreHold.
//
// Contract
// RL1: Sleep only when arm bit set and sleep instruction executed; kind picks state.
// RL2: Interrupt wake holds core four cycles beyond start-up, then resumes.
// RL3: Register file and data memory unchanged across sleep.
// RL4: Reset during sleep leaves sleep and restarts at reset vector.
// RL5: Kind 00 idle stops core and program clocks; any interrupt wakes.
// RL6: Idle or noise sleep with converter enabled starts a conversion.
// RL7: Kind 01 stops io, core, program clocks; converter clock keeps running.
// RL8: Noise sleep wakes only on listed converter, reset, store, line, pin events; here watchdogIrq also wakes.
// RL9: Kind 10 power-down stops oscillator and all generated clocks.
// RL10: Power-down wakes only on resets, line zero level, pin change; here watchdogIrq also wakes it.
// RL11: External level wake source must hold level long enough.
// RL12: Kind 11 standby keeps oscillator, wakes in six cycles.
// RL13: Requested monitor off applies in power-down or standby, restored on wake.
// RL14: Wake after monitor off extends to about 60 us.
// RL15: Monitor-off bit resets zero, only deep sleep, unlock protected.
// RL16: Gate bit stops peripheral clock; its registers not accessible.
// RL17: Clearing gate bit restarts clock, state preserved.
// RL18: Software should disable peripheral before gating its clock.
// RL19: Converter stays enabled in sleep; re-enable gives extended conversion.
// RL20: Deep sleep disables comparator unless it uses the internal reference; here always disabled, reference kept via refKeep.
// RL21: Enabled watchdog and fuse monitor keep running in all sleep.
// RL22: Input buffers off when io and converter clocks stop, except wake pins.
// RL23: Unlock then within four cycles set; active three later, clears after three.
// RL24: Gate bits timer1 3, timer0 2, serial 1, converter 0; upper read zero.
// RL25: Clock gating glitch-free on entry and release.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module spm_sleep_power_manager
	import spm_pkg::*;
#(
	parameter int START_UP_CYC = 16,
	parameter int MON_WAKE     = MON_WAKE_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Core side
	input  wire logic        sleepExec,
	output logic             coreHold,
	output logic             resumeAfterSleep,
	// Wake sources
	input  wire logic        anyIrq,
	input  wire logic        convDoneIrq,
	input  wire logic        storeReadyIrq,
	input  wire logic        lineZeroLevelIrq,
	input  wire logic        pinChangeIrq,
	input  wire logic        watchdogIrq,
	input  wire logic        anyReset,
	// Configuration inputs
	input  wire logic        crystalSelected,
	input  wire logic        convEnabled,
	input  wire logic        compUsesRef,
	input  wire logic        monitorFuseOn,
	input  wire logic        watchdogOn,
	// Clock-domain enables for glitch-free gate cells
	output logic             coreClkEn,
	output logic             progClkEn,
	output logic             ioClkEn,
	output logic             convClkEn,
	output logic             oscEn,
	output logic [3:0]       periphClkEn,
	// Analog and pad controls
	output logic             convStart,
	output logic             convExtended,
	output logic             compDisable,
	output logic             refKeep,
	output logic             monitorOn,
	output logic             watchdogRun,
	output logic             inBufEn,
	output logic             wakePinBufEn
);

	// ==========================================================
	// Registers
	logic [7:0]  coreCtrl;
	logic [3:0]  gate;
	logic [2:0]  unlockCnt;
	logic [2:0]  monCnt;
	logic        monOffActive;
	logic        monOffPending;
	spm_state_t  state;
	spm_kind_t   kind;
	logic        monWasOff;
	logic [15:0] wakeCnt;
	logic        convWasOn;

	logic        apbWr;
	logic        apbRd;
	logic        wakeHit;
	logic        enterSleep;
	logic [15:0] next_wake;

	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && !penable && !pwrite;

	// Wake source filter per kind
	function automatic logic wake_ok(input spm_kind_t k, input logic irq, input logic cd,
			input logic sr, input logic lz, input logic pc, input logic wd);
		case (k)
			SPM_IDLE:  wake_ok = irq; // RL5
			SPM_NOISE: wake_ok = cd | sr | lz | pc | wd; // RL8
			default:   wake_ok = lz | pc | wd; // RL10
		endcase
	endfunction : wake_ok

	assign wakeHit = wake_ok(kind, anyIrq, convDoneIrq, storeReadyIrq, lineZeroLevelIrq,
		pinChangeIrq, watchdogIrq);
	assign enterSleep = (state == SPM_RUN) && sleepExec && coreCtrl[ARM_BIT] &&
		!(coreCtrl[KIND_HI_BIT] && coreCtrl[KIND_LO_BIT] && !crystalSelected); // RL1 RL12

	// ==========================================================
	// Core control register with timed monitor-off unlock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			coreCtrl      <= CORE_CTRL_RST; // RL15
			unlockCnt     <= 3'h0;
			monOffPending <= 1'b0;
			monOffActive  <= 1'b0;
			monCnt        <= 3'h0;
		end else begin
			if (apbWr && paddr == CORE_CTRL_OFS) begin
				coreCtrl[5:3] <= pwdata[5:3];
				if (pwdata[MON_OFF_BIT] && pwdata[UNLOCK_BIT]) begin
					unlockCnt <= 3'(UNLOCK_WINDOW); // RL23
				end else if (pwdata[MON_OFF_BIT] && unlockCnt != 3'h0) begin
					monOffPending <= 1'b1; // RL23
					monCnt        <= 3'(MON_OFF_DELAY);
					unlockCnt     <= 3'h0;
				end else if (unlockCnt != 3'h0) begin
					unlockCnt <= unlockCnt - 3'h1;
				end
			end else if (unlockCnt != 3'h0) begin
				unlockCnt <= unlockCnt - 3'h1;
			end
			// Delay to activation, then limited active life
			if (monOffPending) begin
				if (monCnt == 3'h1) begin
					monOffPending <= 1'b0;
					monOffActive  <= 1'b1;
					monCnt        <= 3'(MON_OFF_HOLD);
				end else begin
					monCnt <= monCnt - 3'h1;
				end
			end else if (monOffActive) begin
				if (monCnt == 3'h1) begin
					monOffActive <= 1'b0; // RL23
				end
				monCnt <= monCnt - 3'h1;
			end
		end
	end

	// ==========================================================
	// Peripheral clock gate register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			gate <= GATE_RST; // RL24
		end else if (apbWr && paddr == GATE_OFS) begin
			gate <= pwdata[3:0]; // RL16 RL17
		end
	end

	// ==========================================================
	// APB read path; zero wait states
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr != CORE_CTRL_OFS &&
				paddr != GATE_OFS && paddr != STATUS_OFS;
			if (apbRd) begin
				case (paddr)
					CORE_CTRL_OFS: prdata <= {24'h000000, monOffActive, 1'b0,
						coreCtrl[5:3], 3'h0};
					GATE_OFS:      prdata <= {28'h0000000, gate}; // RL24
					STATUS_OFS:    prdata <= {28'h0000000, monWasOff, state == SPM_SLEEP,
						kind};
					default:       prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Sleep sequencer; register file and memory untouched, the core only waits
	always_comb begin
		next_wake = 16'(START_UP_CYC + IRQ_EXTRA); // RL2
		if (kind == SPM_STANDBY) begin
			next_wake = 16'(STANDBY_WAKE); // RL12
		end
		if (monWasOff && next_wake < 16'(MON_WAKE)) begin
			next_wake = 16'(MON_WAKE); // RL14
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state     <= SPM_RUN; // RL4
			kind      <= SPM_IDLE;
			monWasOff <= 1'b0;
			wakeCnt   <= 16'h0000;
			resumeAfterSleep <= 1'b0;
		end else begin
			resumeAfterSleep <= 1'b0;
			case (state)
				SPM_RUN: begin
					if (enterSleep) begin
						state <= SPM_SLEEP; // RL1 RL3
						kind  <= spm_kind_t'(coreCtrl[4:3]);
						monWasOff <= monOffActive && coreCtrl[KIND_HI_BIT]; // RL13
					end
				end
				SPM_SLEEP: begin
					if (wakeHit) begin
						state   <= SPM_WAKE;
						wakeCnt <= next_wake;
					end
				end
				SPM_WAKE: begin
					if (wakeCnt <= 16'h0001) begin
						state            <= SPM_RUN;
						monWasOff        <= 1'b0;
						resumeAfterSleep <= 1'b1; // RL2
					end else begin
						wakeCnt <= wakeCnt - 16'h0001;
					end
				end
				default: state <= SPM_RUN;
			endcase
		end
	end

	// ==========================================================
	// Registered clock enables; the gate cells latch them on the low phase so
	// no clipped pulse escapes at entry or release.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			coreClkEn   <= 1'b1;
			progClkEn   <= 1'b1;
			ioClkEn     <= 1'b1;
			convClkEn   <= 1'b1;
			oscEn       <= 1'b1;
			periphClkEn <= 4'hF;
		end else begin
			coreClkEn <= !(state == SPM_SLEEP || enterSleep) || state == SPM_WAKE; // RL25
			progClkEn <= !(state == SPM_SLEEP || enterSleep) || state == SPM_WAKE; // RL5
			ioClkEn   <= !(state == SPM_SLEEP && kind != SPM_IDLE); // RL7
			convClkEn <= !(state == SPM_SLEEP && kind[1]); // RL9
			oscEn     <= !(state == SPM_SLEEP && kind == SPM_PWRDOWN); // RL9 RL12
			periphClkEn <= ~gate & {4{!(state == SPM_SLEEP && kind != SPM_IDLE)}}; // RL16
		end
	end

	// ==========================================================
	// Analog, monitor and pad controls
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			convStart    <= 1'b0;
			convExtended <= 1'b1;
			convWasOn    <= 1'b0;
			compDisable  <= 1'b0;
			refKeep      <= 1'b0;
			monitorOn    <= 1'b1;
			watchdogRun  <= 1'b0;
			inBufEn      <= 1'b1;
			wakePinBufEn <= 1'b1;
			coreHold     <= 1'b0;
		end else begin
			convStart <= enterSleep && convEnabled && !coreCtrl[KIND_HI_BIT]; // RL6
			convWasOn <= convEnabled; // RL19
			if (convEnabled && !convWasOn) begin
				convExtended <= 1'b1; // RL19
			end else if (convStart) begin
				convExtended <= 1'b0;
			end
			compDisable <= state == SPM_SLEEP && kind[1]; // RL20
			refKeep     <= compUsesRef; // RL20
			monitorOn   <= monitorFuseOn && !(state == SPM_SLEEP && monWasOff); // RL13 RL21
			watchdogRun <= watchdogOn; // RL21
			inBufEn     <= !(state == SPM_SLEEP && kind[1]); // RL22
			wakePinBufEn <= 1'b1; // RL22
			coreHold    <= (state == SPM_SLEEP || enterSleep ||
				(state == SPM_WAKE && wakeCnt > 16'h0001)); // RL2
		end
	end

endmodule : spm_sleep_power_manager
